// ---- sfcfe_regs.vh ----
// Opcodes, status byte five layout and frame counts for the serial flash front end
`ifndef SFCFE_REGS_VH
`define SFCFE_REGS_VH

// Opcodes
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST 8'h0B
`define SFCFE_OP_DUAL 8'h3B
`define SFCFE_OP_QUAD 8'h6B
`define SFCFE_OP_XIP 8'hEB
`define SFCFE_OP_XIPDW 8'hE7
`define SFCFE_OP_ER4K 8'h20
`define SFCFE_OP_ER32K 8'h52
`define SFCFE_OP_ER64K 8'hD8
`define SFCFE_OP_CHIP1 8'h60
`define SFCFE_OP_CHIP2 8'hC7
`define SFCFE_OP_RDSR 8'h65
`define SFCFE_OP_WRSR5 8'h71
`define SFCFE_OP_LOCK 8'h6F
`define SFCFE_LOCK_KEY1 8'h4D
`define SFCFE_LOCK_KEY2 8'h67
`define SFCFE_OP_TERM 8'hF0
`define SFCFE_SR5_SEL 8'h05

// Status byte five fields
`define SFCFE_SR5_RESET 8'h00
`define SFCFE_SR5_LOCK 7
`define SFCFE_SR5_DC_HI 6
`define SFCFE_SR5_DC_LO 4
`define SFCFE_SR5_ES 3
`define SFCFE_SR5_PS 2
`define SFCFE_SR5_TERMINATE_ALLOW 1
`define SFCFE_SR5_DWA 0

// Erase kinds
`define SFCFE_ER_4K 2'h0
`define SFCFE_ER_32K 2'h1
`define SFCFE_ER_64K 2'h2
`define SFCFE_ER_CHIP 2'h3

// Frame counts in serial clocks
`define SFCFE_CMD_CLKS 5'h08
`define SFCFE_ADDR1_CLKS 5'h18
`define SFCFE_ADDR4_CLKS 5'h06
`define SFCFE_SEL_CLKS 5'h08
`define SFCFE_DUMMY_SPI 5'h08
`define SFCFE_MODE_CLKS 5'h02

`endif

// ---- sfcfe_front_end.v ----
// Serial flash command front end: framing, decode, status byte five, read data path
`timescale 1ns/1ps
`include "sfcfe_regs.vh"

module sfcfe_front_end #(
	parameter DATA_W = 8,
	parameter FIFO_DEPTH = 2
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Serial pins
	input wire spi_cs_n,
	input wire spi_sclk,
	input wire [3:0] spi_io_in,
	output wire [3:0] spi_io_out,
	output wire [3:0] spi_io_oe,
	// Mode straps from other status bytes
	input wire xip_enable,
	input wire quad_enable_flag,
	// Core suspend state
	input wire erase_suspended,
	input wire program_suspended,
	// Array read stream
	output wire rd_req,
	output wire [23:0] rd_addr,
	output wire rd_stop,
	input wire [DATA_W-1:0] rd_data,
	input wire rd_valid,
	output wire rd_ready,
	// Erase and terminate requests
	output wire erase_req,
	output wire [1:0] erase_kind,
	output wire [23:0] erase_addr,
	output wire term_req,
	// Visible state
	output wire [7:0] status_byte_five,
	output wire xip_active
);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam S_IDLE = 4'h0;
	localparam S_CMD = 4'h1;
	localparam S_ADDR = 4'h2;
	localparam S_DUMMY = 4'h3;
	localparam S_DATA = 4'h4;
	localparam S_WDATA = 4'h5;
	localparam S_KEY1 = 4'h6;
	localparam S_KEY2 = 4'h7;
	localparam S_HOLD = 4'h8;
	localparam S_IGN = 4'h9;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Shift lanes in, MSB first; w is 1, 2 or 4
	function [23:0] shin;
		input [23:0] s;
		input [3:0] io;
		input [2:0] w;
		begin
			case (w)
				3'h4: shin = {s[19:0], io};
				3'h2: shin = {s[21:0], io[1:0]};
				default: shin = {s[22:0], io[0]};
			endcase
		end
	endfunction

	// Place the top bits of a byte on the output lanes
	function [3:0] lanes;
		input [7:0] b;
		input [2:0] w;
		begin
			case (w)
				3'h4: lanes = b[7:4];
				3'h2: lanes = {2'h0, b[7:6]};
				default: lanes = {2'h0, b[7], 1'b0};
			endcase
		end
	endfunction

	// Output enable mask for a lane width
	function [3:0] oemask;
		input [2:0] w;
		begin
			case (w)
				3'h4: oemask = 4'hF;
				3'h2: oemask = 4'h3;
				default: oemask = 4'h2;
			endcase
		end
	endfunction

	// Dummy field to clocks; the mode byte clocks are counted inside
	function [4:0] dclks;
		input [2:0] dc;
		begin
			case (dc)
				3'h0: dclks = 5'h02;
				3'h1: dclks = 5'h04;
				3'h2: dclks = 5'h06;
				default: dclks = 5'h08;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	reg [5:0] s1_q, s2_q, s3_q, st_q;
	reg sclk_prev_q, cs_prev_q;
	wire sclk_st = st_q[5];
	wire cs_st = st_q[4];
	wire [3:0] io_st = st_q[3:0];

	always @(posedge clk)
	begin
		if (rst)
		begin
			s1_q <= 6'h10;
			s2_q <= 6'h10;
			s3_q <= 6'h10;
			st_q <= 6'h10;
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end
		else
		begin
			s1_q <= {spi_sclk, spi_cs_n, spi_io_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change counts only when stages two and three agree
			st_q <= (st_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
			sclk_prev_q <= sclk_st;
			cs_prev_q <= cs_st;
		end
	end

	wire rise = sclk_st & ~sclk_prev_q & ~cs_st;
	wire fall = ~sclk_st & sclk_prev_q & ~cs_st;
	wire frame_start = ~cs_st & cs_prev_q;
	wire frame_end = cs_st & ~cs_prev_q;

	// ------------------------------------------------------------
	// Two-entry read buffer
	// ------------------------------------------------------------
	reg [DATA_W-1:0] mem [0:FIFO_DEPTH-1];
	reg [1:0] wp_q, rp_q, cnt_q;
	wire f_empty = (cnt_q == 2'h0);
	wire f_full = (cnt_q == FIFO_DEPTH[1:0]);
	wire f_pop;
	wire f_push = rd_valid & ~f_full;
	assign rd_ready = ~f_full;

	always @(posedge clk)
	begin
		if (rst || frame_end)
		begin
			wp_q <= 2'h0;
			rp_q <= 2'h0;
			cnt_q <= 2'h0;
		end
		else
		begin
			if (f_push)
			begin
				mem[wp_q[0]] <= rd_data;
				wp_q <= wp_q + 2'h1;
			end
			if (f_pop)
				rp_q <= rp_q + 2'h1;
			cnt_q <= cnt_q + {1'b0, f_push} - {1'b0, f_pop};
		end
	end

	// ------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------
	reg [3:0] st_d, state_q;
	reg [7:0] op_q;
	reg [23:0] sh_q;
	reg [4:0] bit_q, len_q, dum_q;
	reg [2:0] win_q, wout_q;
	reg [7:0] ob_q;
	reg [2:0] ocnt_q;
	reg [3:0] io_out_q, io_oe_q;
	reg lock_q, terminate_allow_q, dwa_q, es_q, ps_q;
	reg [2:0] dc_q;
	reg xip_q, sel_ok_q, pend_q;
	reg [1:0] ekind_q;
	reg [23:0] eaddr_q, raddr_q;
	reg rd_req_q, erase_req_q, term_q, stop_q;

	wire [23:0] sh_n = shin(sh_q, io_st, win_q);
	wire [7:0] byte_n = sh_n[7:0];
	wire last = (bit_q == len_q - 5'h1);
	wire is_xip = (op_q == `SFCFE_OP_XIP) || (op_q == `SFCFE_OP_XIPDW);
	wire is_sr = (op_q == `SFCFE_OP_RDSR);
	wire xip_ok = xip_enable & quad_enable_flag;
	wire [7:0] sr5 = {lock_q, dc_q, es_q, ps_q, terminate_allow_q, dwa_q};
	wire obyte_load = fall && state_q == S_DATA && ocnt_q == 3'h0;
	wire [7:0] src = is_sr ? (sel_ok_q ? sr5 : 8'h00) : mem[rp_q[0]];
	assign f_pop = obyte_load & ~is_sr & ~f_empty;

	// Masked read address for the array
	function [23:0] amask;
		input [23:0] a;
		input e7dw;
		begin
			amask = {2'h0, a[21:2], (e7dw ? 2'h0 : a[1:0])};
		end
	endfunction

	always @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= S_IDLE;
			op_q <= 8'h00;
			sh_q <= 24'h000000;
			bit_q <= 5'h00;
			len_q <= `SFCFE_CMD_CLKS;
			dum_q <= 5'h00;
			win_q <= 3'h1;
			wout_q <= 3'h1;
			ob_q <= 8'h00;
			ocnt_q <= 3'h0;
			io_out_q <= 4'h0;
			io_oe_q <= 4'h0;
			lock_q <= 1'b0;
			dc_q <= 3'h0;
			terminate_allow_q <= 1'b0;
			dwa_q <= 1'b0;
			es_q <= 1'b0;
			ps_q <= 1'b0;
			xip_q <= 1'b0;
			sel_ok_q <= 1'b0;
			pend_q <= 1'b0;
			ekind_q <= `SFCFE_ER_4K;
			eaddr_q <= 24'h000000;
			raddr_q <= 24'h000000;
			rd_req_q <= 1'b0;
			erase_req_q <= 1'b0;
			term_q <= 1'b0;
			stop_q <= 1'b0;
		end
		else
		begin
			es_q <= erase_suspended;
			ps_q <= program_suspended;
			rd_req_q <= 1'b0;
			erase_req_q <= 1'b0;
			term_q <= 1'b0;
			stop_q <= 1'b0;
			if (frame_end)
			begin
				// Erase fires only for a fully received frame
				erase_req_q <= pend_q && state_q == S_HOLD;
				stop_q <= 1'b1;
				pend_q <= 1'b0;
				// XiP continues command-less only with both enables set
				xip_q <= xip_ok && is_xip && state_q == S_DATA;
				io_oe_q <= 4'h0;
				state_q <= S_IDLE;
			end
			else if (frame_start)
			begin
				bit_q <= 5'h00;
				sh_q <= 24'h000000;
				ocnt_q <= 3'h0;
				if (xip_q && xip_ok)
				begin
					win_q <= 3'h4;
					len_q <= `SFCFE_ADDR4_CLKS;
					state_q <= S_ADDR;
				end
				else
				begin
					xip_q <= 1'b0;
					win_q <= 3'h1;
					len_q <= `SFCFE_CMD_CLKS;
					state_q <= S_CMD;
				end
			end
			else if (rise)
			begin
				sh_q <= sh_n;
				bit_q <= last ? 5'h00 : bit_q + 5'h1;
				case (state_q)
					S_CMD:
					if (last)
					begin
						op_q <= byte_n;
						state_q <= st_d;
						// Status write and lock keys are single bytes, like the select byte
						len_q <= (byte_n == `SFCFE_OP_RDSR || byte_n == `SFCFE_OP_WRSR5) ? `SFCFE_SEL_CLKS :
							(byte_n == `SFCFE_OP_LOCK) ? `SFCFE_SEL_CLKS :
							(byte_n == `SFCFE_OP_XIP || byte_n == `SFCFE_OP_XIPDW) ? `SFCFE_ADDR4_CLKS :
							`SFCFE_ADDR1_CLKS;
						win_q <= (byte_n == `SFCFE_OP_XIP || byte_n == `SFCFE_OP_XIPDW) ? 3'h4 : 3'h1;
						pend_q <= byte_n == `SFCFE_OP_CHIP1 || byte_n == `SFCFE_OP_CHIP2;
						ekind_q <= (byte_n == `SFCFE_OP_ER32K) ? `SFCFE_ER_32K :
							(byte_n == `SFCFE_OP_ER64K) ? `SFCFE_ER_64K :
							(byte_n == `SFCFE_OP_ER4K) ? `SFCFE_ER_4K : `SFCFE_ER_CHIP;
						term_q <= byte_n == `SFCFE_OP_TERM && terminate_allow_q;
					end
					S_ADDR:
					if (last)
					begin
						win_q <= 3'h1;
						if (is_sr)
						begin
							sel_ok_q <= byte_n == `SFCFE_SR5_SEL;
							len_q <= `SFCFE_DUMMY_SPI;
							state_q <= S_DUMMY;
						end
						else if (op_q == `SFCFE_OP_ER4K || op_q == `SFCFE_OP_ER32K || op_q == `SFCFE_OP_ER64K)
						begin
							eaddr_q <= amask(sh_n, 1'b0);
							pend_q <= 1'b1;
							state_q <= S_HOLD;
						end
						else
						begin
							raddr_q <= amask(sh_n, op_q == `SFCFE_OP_XIPDW && dwa_q);
							rd_req_q <= 1'b1;
							// XiP reads (EBh, E7h) count the mode byte in the dummy clocks
							len_q <= is_xip ? dclks(dc_q) : `SFCFE_DUMMY_SPI;
							state_q <= (op_q == `SFCFE_OP_READ) ? S_DATA : S_DUMMY;
						end
					end
					S_DUMMY:
					if (last)
						state_q <= S_DATA;
					S_WDATA:
					if (last)
					begin
						// Reserved dummy codes leave the field unchanged
						if (!lock_q && (byte_n[6:4] <= 3'h3))
							dc_q <= byte_n[`SFCFE_SR5_DC_HI:`SFCFE_SR5_DC_LO];
						if (!lock_q)
						begin
							terminate_allow_q <= byte_n[`SFCFE_SR5_TERMINATE_ALLOW];
							dwa_q <= byte_n[`SFCFE_SR5_DWA];
						end
						state_q <= S_HOLD;
					end
					S_KEY1:
					if (last)
						state_q <= (byte_n == `SFCFE_LOCK_KEY1) ? S_KEY2 : S_IGN;
					S_KEY2:
					if (last)
					begin
						if (byte_n == `SFCFE_LOCK_KEY2)
							lock_q <= 1'b1;
						state_q <= S_HOLD;
					end
					default:
						state_q <= state_q;
				endcase
			end
			else if (fall && state_q == S_DATA)
			begin
				// Lanes move only on the falling edge
				if (ocnt_q == 3'h0)
				begin
					ob_q <= src << wout_q;
					io_out_q <= lanes(src, wout_q);
					ocnt_q <= 3'h7 >> (wout_q >> 1);
				end
				else
				begin
					ob_q <= ob_q << wout_q;
					io_out_q <= lanes(ob_q, wout_q);
					ocnt_q <= ocnt_q - 3'h1;
				end
				io_oe_q <= oemask(wout_q);
			end
			if (frame_start || state_q == S_IDLE)
				wout_q <= 3'h1;
			else if (state_q == S_CMD)
				wout_q <= (op_q == `SFCFE_OP_DUAL) ? 3'h2 : 3'h1;
			if (state_q == S_ADDR || state_q == S_DUMMY)
				wout_q <= (op_q == `SFCFE_OP_DUAL) ? 3'h2 :
					(op_q == `SFCFE_OP_QUAD || is_xip) ? 3'h4 : 3'h1;
		end
	end

	// Next state after the command byte
	always @*
	begin
		case (byte_n)
			`SFCFE_OP_READ, `SFCFE_OP_FAST, `SFCFE_OP_DUAL, `SFCFE_OP_QUAD: st_d = S_ADDR;
			`SFCFE_OP_XIP, `SFCFE_OP_XIPDW: st_d = S_ADDR;
			`SFCFE_OP_ER4K, `SFCFE_OP_ER32K, `SFCFE_OP_ER64K: st_d = S_ADDR;
			`SFCFE_OP_CHIP1, `SFCFE_OP_CHIP2: st_d = S_HOLD;
			`SFCFE_OP_RDSR: st_d = S_ADDR;
			`SFCFE_OP_WRSR5: st_d = S_WDATA;
			`SFCFE_OP_LOCK: st_d = S_KEY1;
			`SFCFE_OP_TERM: st_d = S_HOLD;
			default: st_d = S_IGN;
		endcase
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign spi_io_out = io_out_q;
	assign spi_io_oe = io_oe_q;
	assign rd_req = rd_req_q;
	assign rd_addr = raddr_q;
	assign rd_stop = stop_q;
	assign erase_req = erase_req_q;
	assign erase_kind = ekind_q;
	assign erase_addr = eaddr_q;
	assign term_req = term_q;
	assign status_byte_five = sr5;
	assign xip_active = xip_q;

endmodule

// ---- sfcfe_front_end_asserts.sv ----
// Port-level checks for the serial flash command front end
`timescale 1ns/1ps
module sfcfe_front_end_asserts (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Pins and core levels
	input wire spi_cs_n,
	input wire [3:0] spi_io_oe,
	input wire erase_suspended,
	input wire program_suspended,
	// Requests and state
	input wire rd_req,
	input wire [23:0] rd_addr,
	input wire rd_stop,
	input wire erase_req,
	input wire [23:0] erase_addr,
	input wire term_req,
	input wire [7:0] status_byte_five
);
	// ----------------
	// Checks
	// ----------------
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_cs_rise;
		$rose(spi_cs_n);
	endsequence
	sequence s_cs_idle;
		spi_cs_n [*8];
	endsequence
	a_rd_top_zero: assert property (rd_req |-> rd_addr[23:22] == 2'h0)
		else $error("read address top bits set");
	a_er_top_zero: assert property (erase_req |-> erase_addr[23:22] == 2'h0)
		else $error("erase address top bits set");
	a_stop_on_rise: assert property (s_cs_rise |-> ##[1:8] rd_stop)
		else $error("no stop after chip select rise");
	a_oe_idle: assert property (s_cs_idle |-> spi_io_oe == 4'h0)
		else $error("lanes driven outside a frame");
	a_oe_codes: assert property (spi_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("illegal lane enable pattern");
	a_erase_at_end: assert property (erase_req |-> $past(spi_cs_n, 3))
		else $error("erase before frame end");
	a_term_gated: assert property (term_req |-> status_byte_five[1])
		else $error("terminate while disabled");
	a_susp_mirror: assert property (status_byte_five[3:2] == $past({erase_suspended, program_suspended}))
		else $error("suspend flags do not follow core");
	a_lock_sticky: assert property (status_byte_five[7] |=> status_byte_five[7])
		else $error("lock flag cleared");
	a_dc_legal: assert property (!status_byte_five[6])
		else $error("reserved dummy code stored");
endmodule

// ---- sfcfe_host_model.sv ----
// Host serial controller model driving the flash pins
`timescale 1ns/1ps
module sfcfe_host_model (
	// Clock
	input wire clk,
	// Serial pins
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic [3:0] spi_io_in,
	input wire [3:0] spi_io_out
);
	logic [31:0] rx;
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_io_in = 4'h0;
		rx = 32'h0;
	end
	// Long gaps cover the three-stage pin synchroniser
	task automatic sel(input logic v);
		repeat (2) @(negedge clk);
		spi_cs_n = v;
		repeat (10) @(negedge clk);
	endtask
	// Released lanes toggle so a stale value never reads as data
	task automatic clk1(input logic [3:0] v, input int w);
		case (w)
			0: spi_io_in = ~spi_io_in;
			1: spi_io_in = {~spi_io_in[3:1], v[0]};
			default: spi_io_in = v;
		endcase
		repeat (4) @(negedge clk);
		spi_sclk = 1'b1;
		repeat (4) @(negedge clk);
		rx = {rx[30:0], spi_io_out[1]};
		spi_sclk = 1'b0;
	endtask
	task automatic send(input logic [31:0] v, input int n, input int w);
		for (int i = n - 1; i >= 0; i--)
			clk1((w == 4) ? v[4*i+:4] : {3'h0, v[i]}, w);
	endtask
	task automatic recv(input int n);
		repeat (n) clk1(4'h0, 0);
	endtask
endmodule

// ---- sfcfe_front_end_test.sv ----
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`include "sfcfe_regs.vh"
module sfcfe_front_end_test;
	typedef struct {logic [7:0] op; int nb; logic [31:0] addr; logic [1:0] kind; logic [23:0] eaddr;} sfcfe_row_t;
	sfcfe_row_t rows [5];
	logic clk;
	logic rst;
	logic xip_enable;
	logic quad_enable_flag;
	logic erase_suspended;
	logic program_suspended;
	logic rd_valid;
	logic [7:0] rd_data;
	logic took = 1'b0;
	logic streaming = 1'b0;
	logic [23:0] seen_addr, seen_eaddr;
	logic [1:0] seen_kind;
	wire spi_cs_n, spi_sclk, rd_req, rd_stop, rd_ready, erase_req, term_req, xip_active;
	wire [3:0] spi_io_in, spi_io_out, spi_io_oe;
	wire [23:0] rd_addr, erase_addr;
	wire [1:0] erase_kind;
	wire [7:0] status_byte_five;
	int err_count = 0;
	int compares = 0;
	int n_erase = 0;
	int n_term = 0;
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	sfcfe_front_end i_dut (.clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_io_in(spi_io_in),
		.spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe), .xip_enable(xip_enable), .quad_enable_flag(quad_enable_flag),
		.erase_suspended(erase_suspended), .program_suspended(program_suspended), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_stop(rd_stop), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .erase_req(erase_req),
		.erase_kind(erase_kind), .erase_addr(erase_addr), .term_req(term_req), .status_byte_five(status_byte_five),
		.xip_active(xip_active));
	sfcfe_host_model h (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_io_in(spi_io_in),
		.spi_io_out(spi_io_out));
	// ----------------
	// Array stream and monitors
	// ----------------
	// Valid drops after every take, so the buffer sees stalls
	always @(negedge clk)
	begin
		if (took)
			rd_data <= rd_data + 8'h01;
		if (rst || rd_stop)
			rd_data <= 8'hA0;
		// No offer in the stop cycle, so no stale word lands in the flushed buffer
		rd_valid <= streaming & !took & !rd_stop & !rst;
	end
	always @(posedge clk)
	begin
		took <= rd_valid & rd_ready;
		if (rd_req)
		begin
			seen_addr <= rd_addr;
			streaming <= 1'b1;
		end
		if (rd_stop)
			streaming <= 1'b0;
		if (erase_req)
		begin
			n_erase <= n_erase + 1;
			seen_kind <= erase_kind;
			seen_eaddr <= erase_addr;
		end
		if (term_req)
			n_term <= n_term + 1;
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("Compares %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic frame(input logic [7:0] op, input logic [31:0] v, input int n);
		h.sel(1'b0);
		h.send(op, 8, 1);
		h.send(v, n, 1);
		h.sel(1'b1);
	endtask
	task automatic sr_write(input logic [7:0] v, input logic [7:0] exp);
		frame(`SFCFE_OP_WRSR5, v, 8);
		check("status", status_byte_five, exp);
		h.sel(1'b0);
		h.send({`SFCFE_OP_RDSR, `SFCFE_SR5_SEL, 8'h00}, 24, 1);
		h.recv(8);
		check("status read", h.rx[7:0], exp);
		h.sel(1'b1);
	endtask
	// Mode byte rides in the first two of eight dummy clocks
	task automatic xip_frame(input logic [7:0] op, input logic [31:0] a, input logic cmd);
		h.sel(1'b0);
		if (cmd)
			h.send(op, 8, 1);
		h.send(a, 6, 4);
		h.send(8'hA0, 2, 4);
		h.recv(6);
		h.sel(1'b1);
	endtask
	initial
	begin
		#400000;
		err_count++;
		results();
	end
	// ----------------
	// Scenarios
	// ----------------
	initial
	begin
		rst = 1'b1;
		xip_enable = 1'b0;
		quad_enable_flag = 1'b0;
		erase_suspended = 1'b0;
		program_suspended = 1'b0;
		rows[0] = '{8'h20, 24, 32'hFFFFFF, 2'h0, 24'h3FFFFF};
		rows[1] = '{8'h52, 24, 32'h408000, 2'h1, 24'h008000};
		rows[2] = '{8'hD8, 24, 32'h123456, 2'h2, 24'h123456};
		rows[3] = '{8'h60, 0, 32'h0, 2'h3, 24'h0};
		rows[4] = '{8'hC7, 0, 32'h0, 2'h3, 24'h0};
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		check("status reset", status_byte_five, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			frame(rows[i].op, rows[i].addr, rows[i].nb);
			check("erase count", n_erase, i + 1);
			check("erase kind", seen_kind, rows[i].kind);
			if (rows[i].nb > 0)
				check("erase addr", seen_eaddr, rows[i].eaddr);
		end
		frame(8'h20, 32'h1234, 16);
		frame(8'hFF, 32'h20123456, 32);
		check("erase count", n_erase, 5);
		h.sel(1'b0);
		h.send({`SFCFE_OP_READ, 24'hC12345}, 32, 1);
		h.recv(16);
		check("read data", h.rx[15:0], 16'hA0A1);
		h.sel(1'b1);
		check("read addr", seen_addr, 24'h012345);
		h.sel(1'b0);
		h.send({`SFCFE_OP_FAST, 24'h3FFFF0}, 32, 1);
		h.send(32'h0, 8, 1);
		h.recv(8);
		check("fast data", h.rx[7:0], 8'hA0);
		h.sel(1'b1);
		check("fast addr", seen_addr, 24'h3FFFF0);
		frame(`SFCFE_OP_TERM, 32'h0, 0);
		check("term off", n_term, 0);
		sr_write(8'h13, 8'h13);
		sr_write(8'h4B, 8'h13);
		sr_write(8'h33, 8'h33);
		frame(`SFCFE_OP_TERM, 32'h0, 0);
		check("term on", n_term, 1);
		erase_suspended = 1'b1;
		program_suspended = 1'b1;
		repeat (3) @(negedge clk);
		check("suspend", status_byte_five, 8'h3F);
		erase_suspended = 1'b0;
		program_suspended = 1'b0;
		repeat (3) @(negedge clk);
		xip_frame(`SFCFE_OP_XIPDW, 32'h123457, 1'b1);
		check("aligned addr", seen_addr, 24'h123454);
		check("xip off", xip_active, 1'b0);
		xip_enable = 1'b1;
		quad_enable_flag = 1'b1;
		xip_frame(`SFCFE_OP_XIP, 32'h123457, 1'b1);
		check("quad addr", seen_addr, 24'h123457);
		check("xip on", xip_active, 1'b1);
		xip_frame(8'h00, 32'h0ABCDE, 1'b0);
		check("no cmd addr", seen_addr, 24'h0ABCDE);
		check("xip kept", xip_active, 1'b1);
		xip_enable = 1'b0;
		xip_frame(8'h00, 32'h054321, 1'b0);
		check("cmd needed", seen_addr, 24'h0ABCDE);
		check("xip left", xip_active, 1'b0);
		frame(`SFCFE_OP_LOCK, 32'h4D66, 16);
		check("no lock", status_byte_five, 8'h33);
		frame(`SFCFE_OP_LOCK, 32'h4D67, 16);
		check("lock", status_byte_five, 8'hB3);
		sr_write(8'h00, 8'hB3);
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		check("status reset", status_byte_five, 8'h00);
		results();
	end
endmodule
bind sfcfe_front_end sfcfe_front_end_asserts i_chk (.clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_io_oe(spi_io_oe),
	.erase_suspended(erase_suspended), .program_suspended(program_suspended), .rd_req(rd_req), .rd_addr(rd_addr),
	.rd_stop(rd_stop), .erase_req(erase_req), .erase_addr(erase_addr), .term_req(term_req),
	.status_byte_five(status_byte_five));
